// ==== logic/ovm_params.svh ====
// constants of the otg id and vbus monitor: offsets, fields, resets
// assumes inclusion by bare name from the package and the modules
`ifndef OVM_PARAMS_SVH
`define OVM_PARAMS_SVH

// register offsets on the plain register port
`define OVM_ADDR_W          6
`define OVM_DATA_W          8
`define OVM_OFS_OTG_CTRL    6'h0A
`define OVM_OFS_USB_RISE    6'h0D
`define OVM_OFS_USB_FALL    6'h10
`define OVM_OFS_USB_STAT    6'h13
`define OVM_OFS_USB_LATCH   6'h14
`define OVM_OFS_CK_IEN      6'h1D
`define OVM_OFS_CK_STAT     6'h1F
`define OVM_OFS_CK_LATCH    6'h20
`define OVM_OFS_EXT_CTRL    6'h21

// field positions
`define OVM_B_PULLUP        0
`define OVM_B_VBUS          1
`define OVM_B_SVALID        2
`define OVM_B_SEND          3
`define OVM_B_ID_GROUNDED         4
`define OVM_B_FLT_RISE      0
`define OVM_B_FLT_FALL      1
`define OVM_B_IDFLT         0
`define OVM_B_USE_EXT       0
`define OVM_B_PASS          1
`define OVM_B_COMPL         2

// event vector: usb status bits 4..0, id floating on top
`define OVM_EV_W            6
`define OVM_EV_FLT          5

// rx cmd byte layout
`define OVM_RX_VBUS_LO      2
`define OVM_RX_VBUS_HI      3
`define OVM_RX_ID           6
`define OVM_RX_ALT          7

// vbus state encodings carried in the rx cmd
`define OVM_VB_BELOW_END    2'h0
`define OVM_VB_END_TO_VLD   2'h1
`define OVM_VB_VLD_TO_BUS   2'h2
`define OVM_VB_BUS_VALID    2'h3

// reset values
`define OVM_RST_OTG_CTRL    8'h00
`define OVM_RST_USB_EN      8'h1E
`define OVM_RST_CK_IEN      8'h00
`define OVM_RST_EXT_CTRL    8'h00
`define OVM_EXT_IND_LEVEL   1'b1
`define OVM_SYNC_STAGES     2

`endif

// ==== logic/ovm_pkg.sv ====
// types of the otg id and vbus monitor
// assumes ovm_params.svh on the include path
`default_nettype none
package ovm_pkg;
  `include "ovm_params.svh"

  // rx cmd sender states
  typedef enum logic [1:0] {
    OVM_IDLE = 2'b01,
    OVM_SEND = 2'b10
  } ovm_state_t;

  typedef logic [`OVM_DATA_W-1:0] ovm_byte_t;
endpackage
`default_nettype wire

// ==== logic/ovm_sync.sv ====
// bank of two-stage synchronisers for the analog comparator outputs
// assumes asynchronous levels in, one clock domain out
`timescale 1ns/1ps
`default_nettype none
module ovm_sync #(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  // *************************************************************
  // synchroniser per bit
  // *************************************************************
  // first stage feeds only the second stage
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_r[i]   <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_r[i]   <= async_in[i];
          sync_out[i] <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule // ovm_sync
`default_nettype wire

// ==== logic/ovm_edge.sv ====
// edge detector and sticky change latch per status flag
// assumes flags already synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module ovm_edge #(
  parameter int W = 6
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] flag_in,
  input  wire logic [W-1:0] rise_en,
  input  wire logic [W-1:0] fall_en,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] latch_q,
  output logic      [W-1:0] change_q,
  output logic      [W-1:0] event_q
);
  logic [W-1:0] prev_r;
  logic [W-1:0] rise;
  logic [W-1:0] fall;

  // *************************************************************
  // per bit edges and latch
  // *************************************************************
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign rise[i] = flag_in[i] & ~prev_r[i];
      assign fall[i] = ~flag_in[i] & prev_r[i];
      // set beats clear so an edge in the clear cycle is kept
      always_ff @(posedge clk) begin
        if (rst) begin
          prev_r[i]   <= 1'b0;
          latch_q[i]  <= 1'b0;
          change_q[i] <= 1'b0;
          event_q[i]  <= 1'b0;
        end else begin
          prev_r[i]   <= flag_in[i];
          change_q[i] <= rise[i] | fall[i];
          event_q[i]  <= (rise[i] & rise_en[i]) | (fall[i] & fall_en[i]);
          if ((rise[i] & rise_en[i]) | (fall[i] & fall_en[i])) begin
            latch_q[i] <= 1'b1;
          end else if (clr[i]) begin
            latch_q[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate
endmodule // ovm_edge
`default_nettype wire

// ==== logic/ovm_monitor.sv ====
// otg id and vbus monitor: registers, flag gating, rx cmd sender
// assumes raw comparator levels from the analog front end and a
// link side sender that takes rx cmds on the same clock
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ovm_params.svh"

// Summary of operation
// - pull-up bit turns on strong id pull-up
// - float enables send rx cmd on float change
// - float change rx cmd sets alt flag
// - grounded and floating reflect the id termination
// - clearing all enables leaves only weak pull-up
// - id grounded readable at usb status bit 4
// - enabled id grounded edges raise an interrupt
// - id floating readable at carkit status bit 0
// - comparator outputs readable in usb status
// - session end flag rises when vbus drops
// - both enables clear: session end off, reads 0
// - every session valid change sends rx cmd
// - session valid enables only mask its interrupts
// - both enables clear: vbus valid off, reads 0
// - external indicator tied high, select off at reset
// - select, pass, invert choose rx cmd vbus source
module ovm_monitor (
  input  wire logic                  clk,
  input  wire logic                  rst,
  // register port
  input  wire logic [`OVM_ADDR_W-1:0] reg_addr,
  input  wire ovm_pkg::ovm_byte_t     reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output ovm_pkg::ovm_byte_t          reg_rdata,
  // raw analog comparator levels
  input  wire logic                  cmp_id_gnd,
  input  wire logic                  cmp_id_float,
  input  wire logic                  cmp_sess_end,
  input  wire logic                  cmp_sess_vld,
  input  wire logic                  cmp_vbus_vld,
  // analog controls
  output logic                       id_pullup_on,
  output logic                       id_float_cmp_en,
  output logic                       sess_end_cmp_en,
  output logic                       vbus_vld_cmp_en,
  // rx cmd toward the ulpi sender
  output logic                       rxcmd_valid,
  output ovm_pkg::ovm_byte_t          rxcmd_data,
  input  wire logic                  rxcmd_ready
);
  import ovm_pkg::*;

  // *************************************************************
  // declarations
  // *************************************************************
  ovm_byte_t         otg_ctrl_r;
  ovm_byte_t         usb_rise_r;
  ovm_byte_t         usb_fall_r;
  ovm_byte_t         ck_ien_r;
  ovm_byte_t         ext_ctrl_r;
  ovm_byte_t         rdata_nxt;
  ovm_byte_t         rx_nxt;
  ovm_state_t        state_r;
  logic [4:0]        raw_sync;
  logic              id_gnd_s;
  logic              id_flt_s;
  logic              sess_end_s;
  logic              sess_vld_s;
  logic              vbus_vld_s;
  logic              id_pullup_enable;
  logic              float_rise_irq_en;
  logic              float_fall_irq_en;
  logic              id_grounded;
  logic              id_floating;
  logic              session_end_flag;
  logic              session_valid_flag;
  logic              vbus_valid_flag;
  logic              send_on;
  logic              vbus_on;
  logic              float_on;
  logic              ext_ind;
  logic              vbus_src;
  logic [1:0]        vbus_enc;
  logic [1:0]        vbus_enc_r;
  logic              enc_change;
  logic [`OVM_EV_W-1:0] ev_flags;
  logic [`OVM_EV_W-1:0] ev_rise_en;
  logic [`OVM_EV_W-1:0] ev_fall_en;
  logic [`OVM_EV_W-1:0] ev_clr;
  logic [`OVM_EV_W-1:0] ev_latch;
  logic [`OVM_EV_W-1:0] ev_change;
  logic [`OVM_EV_W-1:0] ev_event;
  logic              trig;
  logic              trig_alt;
  logic              pend_r;
  logic              alt_r;
  logic              take;
  logic              rd_usb_latch;
  logic              rd_ck_latch;

  // *************************************************************
  // input synchronisers
  // *************************************************************
  ovm_sync #(
    .W (5)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({cmp_vbus_vld, cmp_sess_vld, cmp_sess_end,
                cmp_id_float, cmp_id_gnd}),
    .sync_out (raw_sync)
  );

  assign id_gnd_s   = raw_sync[0];
  assign id_flt_s   = raw_sync[1];
  assign sess_end_s = raw_sync[2];
  assign sess_vld_s = raw_sync[3];
  assign vbus_vld_s = raw_sync[4];

  // *************************************************************
  // control fields
  // *************************************************************
  assign id_pullup_enable  = otg_ctrl_r[`OVM_B_PULLUP];
  assign float_rise_irq_en = ck_ien_r[`OVM_B_FLT_RISE];
  assign float_fall_irq_en = ck_ien_r[`OVM_B_FLT_FALL];

  // a comparator counts as off only when both of its edges are off
  assign send_on  = usb_rise_r[`OVM_B_SEND] | usb_fall_r[`OVM_B_SEND];
  assign vbus_on  = usb_rise_r[`OVM_B_VBUS] | usb_fall_r[`OVM_B_VBUS];
  assign float_on = float_rise_irq_en | float_fall_irq_en;

  // *************************************************************
  // gated status flags
  // *************************************************************
  // the front end decides the levels per termination
  assign id_grounded        = id_gnd_s;
  assign id_floating        = float_on & id_flt_s;
  // comparator high once vbus sits under the end threshold
  assign session_end_flag   = send_on & sess_end_s;
  // session valid has no off state: its enables mask only irqs
  assign session_valid_flag = sess_vld_s;
  assign vbus_valid_flag    = vbus_on & vbus_vld_s;

  // *************************************************************
  // external vbus indicator select
  // *************************************************************
  // there is no indicator pin, so the input sits at one
  assign ext_ind = `OVM_EXT_IND_LEVEL;

  // complement wins, then pass-through, else internal comparator
  always_comb begin
    vbus_src = vbus_valid_flag;
    if (ext_ctrl_r[`OVM_B_USE_EXT]) begin
      if (ext_ctrl_r[`OVM_B_COMPL]) begin
        vbus_src = ~ext_ind;
      end else if (ext_ctrl_r[`OVM_B_PASS]) begin
        vbus_src = ext_ind;
      end else begin
        vbus_src = vbus_valid_flag & ext_ind;
      end
    end
  end

  // vbus state encoding from the comparator ladder
  always_comb begin
    if (vbus_src) begin
      vbus_enc = `OVM_VB_BUS_VALID;
    end else if (session_valid_flag) begin
      vbus_enc = `OVM_VB_VLD_TO_BUS;
    end else if (!session_end_flag) begin
      vbus_enc = `OVM_VB_END_TO_VLD;
    end else begin
      vbus_enc = `OVM_VB_BELOW_END;
    end
  end

  // *************************************************************
  // edge latches
  // *************************************************************
  assign ev_flags   = {id_floating, id_grounded, session_end_flag,
                       session_valid_flag, vbus_valid_flag, 1'b0};
  assign ev_rise_en = {float_rise_irq_en, usb_rise_r[4:0]};
  assign ev_fall_en = {float_fall_irq_en, usb_fall_r[4:0]};

  // reading a latch register clears it
  assign rd_usb_latch = reg_rd && (reg_addr == `OVM_OFS_USB_LATCH);
  assign rd_ck_latch  = reg_rd && (reg_addr == `OVM_OFS_CK_LATCH);
  assign ev_clr       = {rd_ck_latch, {(`OVM_EV_W-1){rd_usb_latch}}};

  ovm_edge #(
    .W (`OVM_EV_W)
  ) u_edge (
    .clk      (clk),
    .rst      (rst),
    .flag_in  (ev_flags),
    .rise_en  (ev_rise_en),
    .fall_en  (ev_fall_en),
    .clr      (ev_clr),
    .latch_q  (ev_latch),
    .change_q (ev_change),
    .event_q  (ev_event)
  );

  // *************************************************************
  // rx cmd triggers
  // *************************************************************
  // float changes go out flagged as alternate interrupts
  assign trig_alt = ev_change[`OVM_EV_FLT] & float_on;
  assign trig = enc_change
              | ev_change[`OVM_B_ID_GROUNDED]
              | (|ev_event[`OVM_EV_W-2:0])
              | trig_alt;

  // remember the last encoding so a source switch is reported too;
  // reset to the code that all-low flags give, so no false rx cmd
  always_ff @(posedge clk) begin
    if (rst) begin
      vbus_enc_r <= `OVM_VB_END_TO_VLD;
      enc_change <= 1'b0;
    end else begin
      vbus_enc_r <= vbus_enc;
      enc_change <= (vbus_enc != vbus_enc_r)
                  | ev_change[`OVM_B_SVALID];
    end
  end

  // *************************************************************
  // rx cmd sender
  // *************************************************************
  assign take = (state_r == OVM_IDLE) && pend_r;

  // pending flags: a new trigger in the load cycle is kept
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_r <= 1'b0;
      alt_r  <= 1'b0;
    end else begin
      pend_r <= trig | (pend_r & ~take);
      alt_r  <= trig_alt | (alt_r & ~take);
    end
  end

  // byte built from live status at load time
  always_comb begin
    rx_nxt                                  = '0;
    rx_nxt[`OVM_RX_VBUS_HI:`OVM_RX_VBUS_LO] = vbus_enc;
    rx_nxt[`OVM_RX_ID]                      = id_grounded;
    rx_nxt[`OVM_RX_ALT]                     = alt_r;
  end

  // one byte held until the sender takes it
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r     <= OVM_IDLE;
      rxcmd_valid <= 1'b0;
      rxcmd_data  <= '0;
    end else begin
      unique case (state_r)
        OVM_IDLE: begin
          if (pend_r) begin
            rxcmd_data  <= rx_nxt;
            rxcmd_valid <= 1'b1;
            state_r     <= OVM_SEND;
          end
        end
        OVM_SEND: begin
          if (rxcmd_ready) begin
            rxcmd_valid <= 1'b0;
            state_r     <= OVM_IDLE;
          end
        end
        default: begin
          rxcmd_valid <= 1'b0;
          state_r     <= OVM_IDLE;
        end
      endcase
    end
  end

  // *************************************************************
  // register writes
  // *************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      otg_ctrl_r <= `OVM_RST_OTG_CTRL;
      usb_rise_r <= `OVM_RST_USB_EN;
      usb_fall_r <= `OVM_RST_USB_EN;
      ck_ien_r   <= `OVM_RST_CK_IEN;
      ext_ctrl_r <= `OVM_RST_EXT_CTRL;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `OVM_OFS_OTG_CTRL: otg_ctrl_r <= reg_wdata;
        `OVM_OFS_USB_RISE: usb_rise_r <= reg_wdata;
        `OVM_OFS_USB_FALL: usb_fall_r <= reg_wdata;
        `OVM_OFS_CK_IEN:   ck_ien_r   <= reg_wdata;
        `OVM_OFS_EXT_CTRL: ext_ctrl_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // *************************************************************
  // register reads
  // *************************************************************
  // unmapped addresses read zero
  always_comb begin
    rdata_nxt = '0;
    unique case (reg_addr)
      `OVM_OFS_OTG_CTRL: rdata_nxt = otg_ctrl_r;
      `OVM_OFS_USB_RISE: rdata_nxt = usb_rise_r;
      `OVM_OFS_USB_FALL: rdata_nxt = usb_fall_r;
      `OVM_OFS_USB_STAT: begin
        rdata_nxt[`OVM_B_VBUS]   = vbus_valid_flag;
        rdata_nxt[`OVM_B_SVALID] = session_valid_flag;
        rdata_nxt[`OVM_B_SEND]   = session_end_flag;
        rdata_nxt[`OVM_B_ID_GROUNDED]  = id_grounded;
      end
      `OVM_OFS_USB_LATCH: rdata_nxt[4:0] = ev_latch[4:0];
      `OVM_OFS_CK_IEN:    rdata_nxt = ck_ien_r;
      `OVM_OFS_CK_STAT:   rdata_nxt[`OVM_B_IDFLT] = id_floating;
      `OVM_OFS_CK_LATCH:  rdata_nxt[0] = ev_latch[`OVM_EV_FLT];
      `OVM_OFS_EXT_CTRL:  rdata_nxt = ext_ctrl_r;
      default: ;
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= '0;
    end
  end

  // *************************************************************
  // analog controls
  // *************************************************************
  // clearing pull-up and float enables leaves only the weak one
  always_ff @(posedge clk) begin
    if (rst) begin
      id_pullup_on    <= 1'b0;
      id_float_cmp_en <= 1'b0;
      sess_end_cmp_en <= 1'b0;
      vbus_vld_cmp_en <= 1'b0;
    end else begin
      id_pullup_on    <= id_pullup_enable;
      id_float_cmp_en <= float_on;
      sess_end_cmp_en <= send_on;
      vbus_vld_cmp_en <= vbus_on;
    end
  end
endmodule // ovm_monitor
`default_nettype wire

// ==== tb/ovm_props.sv ====
// concurrent checks on the ports of the otg id and vbus monitor
// assumes one clock, sync active-high reset, two-flop input sync
`timescale 1ns/1ps
`default_nettype none
`include "ovm_params.svh"
module ovm_props (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic [`OVM_ADDR_W-1:0] reg_addr,
  input wire ovm_pkg::ovm_byte_t     reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire ovm_pkg::ovm_byte_t     reg_rdata,
  input wire logic                   cmp_id_gnd,
  input wire logic                   cmp_id_float,
  input wire logic                   cmp_sess_end,
  input wire logic                   cmp_sess_vld,
  input wire logic                   cmp_vbus_vld,
  input wire logic                   id_pullup_on,
  input wire logic                   id_float_cmp_en,
  input wire logic                   sess_end_cmp_en,
  input wire logic                   vbus_vld_cmp_en,
  input wire logic                   rxcmd_valid,
  input wire ovm_pkg::ovm_byte_t     rxcmd_data,
  input wire logic                   rxcmd_ready
);
  import ovm_pkg::*;
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // access decodes shared by several checks
  wire logic wr_otg = reg_wr && reg_addr == `OVM_OFS_OTG_CTRL;
  wire logic wr_ck  = reg_wr && reg_addr == `OVM_OFS_CK_IEN;
  wire logic rd_st  = reg_rd && reg_addr == `OVM_OFS_USB_STAT;
  wire logic rd_ck  = reg_rd && reg_addr == `OVM_OFS_CK_STAT;
  // later write may land one cycle on, so wait for a quiet cycle
  property p_pullup;
    wr_otg ##1 !wr_otg |=> id_pullup_on == $past(reg_wdata[0], 2);
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up does not follow control write");
  property p_flt_en;
    wr_ck ##1 !wr_ck |=> id_float_cmp_en == ($past(reg_wdata[1:0], 2) != 2'h0);
  endproperty
  a_flt_en: assert property (p_flt_en)
    else $error("float comparator enable wrong");
  property p_vbus_off;
    rd_st && !vbus_vld_cmp_en ##1 !vbus_vld_cmp_en |-> reg_rdata[1] == 1'b0;
  endproperty
  a_vbus_off: assert property (p_vbus_off)
    else $error("disabled vbus valid reads one");
  property p_send_off;
    rd_st && !sess_end_cmp_en ##1 !sess_end_cmp_en |-> reg_rdata[3] == 1'b0;
  endproperty
  a_send_off: assert property (p_send_off)
    else $error("disabled session end reads one");
  property p_flt_off;
    rd_ck && !id_float_cmp_en ##1 !id_float_cmp_en |-> reg_rdata[0] == 1'b0;
  endproperty
  a_flt_off: assert property (p_flt_off)
    else $error("disabled float indication reads one");
  // pin held over three samples with no reset in between
  property p_gnd_stat;
    rd_st && !$past(rst) && !$past(rst, 2) && $stable(cmp_id_gnd) &&
      $past(cmp_id_gnd) == $past(cmp_id_gnd, 2)
      |=> reg_rdata[4] == $past(cmp_id_gnd);
  endproperty
  a_gnd_stat: assert property (p_gnd_stat)
    else $error("id grounded status differs from pin");
  property p_hold;
    rxcmd_valid && !rxcmd_ready |=> rxcmd_valid && $stable(rxcmd_data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("rx cmd dropped or changed before ready");
  property p_gap;
    rxcmd_valid && rxcmd_ready |=> !rxcmd_valid;
  endproperty
  a_gap: assert property (p_gap)
    else $error("no idle cycle between rx cmds");
  property p_sv_cmd;
    $changed(cmp_sess_vld) |-> ##[1:30] rxcmd_valid;
  endproperty
  a_sv_cmd: assert property (p_sv_cmd)
    else $error("session valid change sent no rx cmd");
  c_hand: cover property (rxcmd_valid && rxcmd_ready);
  c_alt: cover property (rxcmd_valid && rxcmd_data[7]);
  c_stat: cover property (rd_st && cmp_id_gnd);
endmodule // ovm_props
bind ovm_monitor ovm_props ovm_props_u (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .cmp_id_gnd(cmp_id_gnd), .cmp_id_float(cmp_id_float),
  .cmp_sess_end(cmp_sess_end), .cmp_sess_vld(cmp_sess_vld),
  .cmp_vbus_vld(cmp_vbus_vld), .id_pullup_on(id_pullup_on),
  .id_float_cmp_en(id_float_cmp_en), .sess_end_cmp_en(sess_end_cmp_en),
  .vbus_vld_cmp_en(vbus_vld_cmp_en), .rxcmd_valid(rxcmd_valid),
  .rxcmd_data(rxcmd_data), .rxcmd_ready(rxcmd_ready));
`default_nettype wire

// ==== tb/ovm_link_model.sv ====
// link side taker of rx cmds, with a fast and a stalling pace
// assumes the same clock and reset as the monitor
`timescale 1ns/1ps
`default_nettype none
`include "ovm_params.svh"
module ovm_link_model (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               slow,
  input  wire logic               rxcmd_valid,
  input  wire ovm_pkg::ovm_byte_t rxcmd_data,
  output logic                    rxcmd_ready,
  output ovm_pkg::ovm_byte_t      last_cmd,
  output int                      n_cmds,
  output logic                    vbus_seen
);
  import ovm_pkg::*;
  // ****************************************
  // handshake
  // ****************************************
  logic [2:0] wait_r;
  logic       ready_r = 1'b0;
  assign rxcmd_ready = ready_r;
  // one-cycle ready after a stall; a slow link keeps the sender waiting
  always_ff @(posedge clk) begin
    if (rst || !rxcmd_valid || ready_r) begin
      wait_r <= 3'h0;
      ready_r <= 1'b0;
    end else begin
      wait_r <= wait_r + 3'h1;
      ready_r <= wait_r >= (slow ? 3'h4 : 3'h0);
    end
  end
  // byte taken at the accepting edge only
  always_ff @(posedge clk) begin
    if (rst) begin
      n_cmds <= 0;
      last_cmd <= 8'h00;
    end else if (rxcmd_valid && ready_r) begin
      n_cmds <= n_cmds + 1;
      last_cmd <= rxcmd_data;
    end
  end
  // presence judged from session valid, never from the vbus valid bit
  assign vbus_seen = last_cmd[`OVM_RX_VBUS_HI];
endmodule // ovm_link_model
`default_nettype wire

// ==== tb/tb.sv ====
// testbench of the otg id and vbus monitor: table pass, then edge cases
// assumes the link model on the rx cmd side and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "ovm_params.svh"
`define CHK(g, e) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("FAIL %0t got %0h exp %0h", $time, (g), (e)); \
  end \
end
module tb;
  import ovm_pkg::*;
  // ****************************************
  // stimulus and checks
  // ****************************************
  typedef struct packed {
    logic [4:0] pins; // gnd, float, sess end, sess valid, vbus valid
    logic [2:0] ext;
    logic [1:0] fen;
    logic [1:0] enc;
  } ovm_tb_row_t;
  logic                   clk, rst, reg_wr, reg_rd, rdy, slow, rx_valid;
  logic                   pull_on, flt_en, se_en, vb_en;
  logic [`OVM_ADDR_W-1:0] reg_addr;
  ovm_byte_t              reg_wdata, reg_rdata, rx_data, last_cmd, got;
  logic [4:0]             pins;
  int                     num_errors, n_compared, cyc, n_cmds, base;
  // vbus source table walks every pass and invert mix with select on
  ovm_tb_row_t rows [11] = '{
    {5'h1A, 3'h0, 2'h3, 2'h2}, {5'h13, 3'h0, 2'h3, 2'h3},
    {5'h02, 3'h3, 2'h3, 2'h3}, {5'h03, 3'h7, 2'h3, 2'h2},
    {5'h03, 3'h1, 2'h3, 2'h3}, {5'h02, 3'h1, 2'h3, 2'h2},
    {5'h03, 3'h5, 2'h3, 2'h2}, {5'h03, 3'h6, 2'h3, 2'h3},
    {5'h04, 3'h0, 2'h3, 2'h0}, {5'h00, 3'h0, 2'h3, 2'h1},
    {5'h18, 3'h0, 2'h0, 2'h1}};
  ovm_monitor dut_u (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmp_id_gnd(pins[4]), .cmp_id_float(pins[3]), .cmp_sess_end(pins[2]),
    .cmp_sess_vld(pins[1]), .cmp_vbus_vld(pins[0]),
    .id_pullup_on(pull_on), .id_float_cmp_en(flt_en),
    .sess_end_cmp_en(se_en), .vbus_vld_cmp_en(vb_en),
    .rxcmd_valid(rx_valid), .rxcmd_data(rx_data), .rxcmd_ready(rdy));
  ovm_link_model link_u (
    .clk(clk), .rst(rst), .slow(slow), .rxcmd_valid(rx_valid),
    .rxcmd_data(rx_data), .rxcmd_ready(rdy), .last_cmd(last_cmd),
    .n_cmds(n_cmds), .vbus_seen());
  // free-running clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // a hang counts as a mismatch and still reaches the report
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [`OVM_ADDR_W-1:0] a, input ovm_byte_t d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [`OVM_ADDR_W-1:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
  endtask
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = 8'h00;
    pins = 5'h00;
    slow = 1'b0;
    cyc = 0;
    num_errors = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wr(`OVM_OFS_OTG_CTRL, 8'h01);
    idle(2);
    `CHK(pull_on, 1'b1)
    foreach (rows[i]) begin
      wr(`OVM_OFS_EXT_CTRL, {5'h00, rows[i].ext});
      wr(`OVM_OFS_CK_IEN, {6'h00, rows[i].fen});
      pins <= rows[i].pins;
      idle(30);
      rd(`OVM_OFS_USB_STAT);
      `CHK(got & 8'h1E, {3'h0, rows[i].pins[4], rows[i].pins[2:0], 1'b0})
      rd(`OVM_OFS_CK_STAT);
      `CHK(got[0], rows[i].pins[3] & (|rows[i].fen))
      `CHK(last_cmd[3:2], rows[i].enc)
      `CHK(last_cmd[6], rows[i].pins[4])
    end
    // stalling link from here on; float fall alone must flag alt
    slow = 1'b1;
    wr(`OVM_OFS_CK_IEN, 8'h03);
    idle(30);
    base = n_cmds;
    pins <= 5'h10;
    idle(30);
    `CHK(n_cmds > base, 1'b1)
    `CHK(last_cmd[7], 1'b1)
    rd(`OVM_OFS_CK_LATCH);
    `CHK(got, 8'h01)
    rd(`OVM_OFS_CK_LATCH);
    `CHK(got, 8'h00)
    // grounded edge latched once, cleared by the read
    pins <= 5'h00;
    idle(20);
    rd(`OVM_OFS_USB_LATCH);
    pins <= 5'h10;
    idle(20);
    rd(`OVM_OFS_USB_LATCH);
    `CHK(got[4], 1'b1)
    rd(`OVM_OFS_USB_LATCH);
    `CHK(got[4], 1'b0)
    // single-role link turns every usb edge enable off
    wr(`OVM_OFS_USB_RISE, 8'h00);
    wr(`OVM_OFS_USB_FALL, 8'h00);
    pins <= 5'h00;
    idle(20);
    pins <= 5'h17;
    idle(20);
    rd(`OVM_OFS_USB_LATCH);
    `CHK(got[4], 1'b0)
    `CHK(se_en, 1'b0)
    `CHK(vb_en, 1'b0)
    rd(`OVM_OFS_USB_STAT);
    `CHK(got & 8'h0E, 8'h04)
    base = n_cmds;
    pins <= 5'h15;
    idle(30);
    `CHK(n_cmds > base, 1'b1)
    wr(`OVM_OFS_OTG_CTRL, 8'h00);
    wr(`OVM_OFS_CK_IEN, 8'h00);
    idle(2);
    `CHK(pull_on, 1'b0)
    `CHK(flt_en, 1'b0)
    // second reset in mid-run; unmapped write must change nothing
    rst <= 1'b1;
    idle(10);
    rst <= 1'b0;
    wr(6'h3F, 8'hFF);
    rd(`OVM_OFS_OTG_CTRL);
    `CHK(got, 8'h00)
    rd(`OVM_OFS_USB_RISE);
    `CHK(got, 8'h1E)
    rd(`OVM_OFS_USB_FALL);
    `CHK(got, 8'h1E)
    rd(`OVM_OFS_EXT_CTRL);
    `CHK(got, 8'h00)
    rd(6'h3F);
    `CHK(got, 8'h00)
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
